// file: logic/pin_cfg_pkg.sv
// Purpose: Shared constants for the four-pin configuration block.
// Assumes: Byte-wide registers on a plain strobe port.
// Notes: Field positions are relative to a four-bit pin slot.
package pin_cfg_pkg;
   localparam int PIN_COUNT = 4;
   localparam logic [7:0] ADDR_PIN0 = 8'h1D;
   localparam logic [7:0] ADDR_PIN12 = 8'h1E;
   localparam logic [7:0] ADDR_PIN3 = 8'h1F;
   localparam logic [7:0] ADDR_CTRL = 8'h30;
   localparam logic [7:0] ADDR_STATUS = 8'h31;
   // Revision value is arbitrary.
   localparam logic [3:0] REVISION_VALUE = 4'h5;
   localparam int SLOT_LO = 0;
   localparam int SLOT_HI = 4;
   localparam int FLD_EN = 0;
   localparam int FLD_DIR = 1;
   localparam int FLD_LINK = 2;
   localparam int FLD_VAL = 3;
   localparam logic [3:0] SLOT_RESET = 4'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [1:0] MODE_FUNC = 2'h0;
   localparam logic [1:0] MODE_OUT = 2'h1;
   localparam logic [1:0] MODE_TRI = 2'h2;
   localparam logic [1:0] MODE_IN = 2'h3;
   typedef enum logic [1:0] {PIN_FUNCTIONAL, PIN_TRISTATE, PIN_OUTPUT, PIN_INPUT} pin_mode_type;
endpackage : pin_cfg_pkg

// file: logic/pin_slot_if.sv
// Purpose: Carries one pin slot's settings between modules.
// Assumes: Single clock domain.
// Notes: Four bits: value, link enable, direction, enable.
`timescale 1ns/1ns
`default_nettype none
interface pin_slot_if;
   logic [3:0] slot;
   modport source (output slot);
   modport sink (input slot);
endinterface : pin_slot_if
`default_nettype wire

// file: logic/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement check.
// Assumes: Input is asynchronous to the clock.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none
module pin_sync
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic async_in,
   output logic sync_out
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic held_reg;
   logic held_next;
   // A change counts only once stages two and three agree.
   always_comb
   begin
      stage_next = {stage_reg[1:0], async_in};
      held_next = (stage_reg[2] == stage_reg[1]) ? stage_reg[2] : held_reg;
   end
   // Registered state.
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         stage_reg <= 3'h0;
         held_reg <= 1'b0;
      end
      else
      begin
         stage_reg <= stage_next;
         held_reg <= held_next;
      end
   end
   assign sync_out = held_reg;
endmodule : pin_sync
`default_nettype wire

// file: logic/pin_driver.sv
// Purpose: Resolves one pin's driver from its settings slot.
// Assumes: Settings and remote value are on the system clock.
// Notes: Output enable is low while driving.
`timescale 1ns/1ns
`default_nettype none
module pin_driver
(
   pin_slot_if.sink cfg,
   input wire logic remote_value_in,
   input wire logic func_value_in,
   output logic drive_value_out,
   output logic drive_oe_n_out,
   output pin_cfg_pkg::pin_mode_type mode_out
);
   logic [1:0] dir_en;
   assign dir_en = {cfg.slot[pin_cfg_pkg::FLD_DIR], cfg.slot[pin_cfg_pkg::FLD_EN]};
   // Remote control overrides the local code entirely.
   always_comb
   begin
      drive_value_out = 1'b0;
      drive_oe_n_out = 1'b1;
      mode_out = pin_cfg_pkg::PIN_TRISTATE;
      if (cfg.slot[pin_cfg_pkg::FLD_LINK])
      begin
         drive_value_out = remote_value_in;
         drive_oe_n_out = 1'b0;
         mode_out = pin_cfg_pkg::PIN_OUTPUT;
      end
      else
      begin
         unique case (dir_en)
            pin_cfg_pkg::MODE_FUNC:
            begin
               drive_value_out = func_value_in;
               drive_oe_n_out = 1'b0;
               mode_out = pin_cfg_pkg::PIN_FUNCTIONAL;
            end
            pin_cfg_pkg::MODE_TRI:
            begin
               mode_out = pin_cfg_pkg::PIN_TRISTATE;
            end
            pin_cfg_pkg::MODE_OUT:
            begin
               drive_value_out = cfg.slot[pin_cfg_pkg::FLD_VAL];
               drive_oe_n_out = 1'b0;
               mode_out = pin_cfg_pkg::PIN_OUTPUT;
            end
            pin_cfg_pkg::MODE_IN:
            begin
               mode_out = pin_cfg_pkg::PIN_INPUT;
            end
         endcase
      end
   end
endmodule : pin_driver
`default_nettype wire

// file: logic/pin_cfg_top.sv
// Purpose: Register file and pin steering for four configurable pins.
// Assumes: Plain strobe bus, read data one cycle after the read strobe.
// Notes: Per-pin settings steer to one of two ports; the rules follow.
// Function
// - Code 00 keeps functional output; code 10 tri-states the pin.
// - Code 01 is general output; code 11 is general input.
// - Local value drives pin only when enabled, output, remote off.
// - Remote enable forces output with the value from the link.
// - Remote enable low ignores link values, follows local settings.
// - Port select steers every setting to the second port's pins.
// - Pin 0 at 0x1D, pins 1 and 2 at 0x1E, pin 3 at 0x1F.
// - Shared register: second pin in bits 7-4, first in 3-0.
// - Pin 0 upper nibble is revision; pin 3 upper nibble reserved.
// - Per-pin codes override the global direction and enable.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module pin_cfg_top
(
   input wire logic CLK_SYS_IN,
   input wire logic SRST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   input wire logic [3:0] REMOTE_VALUE_IN,
   input wire logic [3:0] FUNC_VALUE_IN,
   input wire logic [3:0] GLOBAL_DIR_EN_IN,
   input wire logic [3:0] PIN_A_IN,
   output logic [3:0] PIN_A_OUT,
   output logic [3:0] PIN_A_OE_N_OUT,
   input wire logic [3:0] PIN_B_IN,
   output logic [3:0] PIN_B_OUT,
   output logic [3:0] PIN_B_OE_N_OUT
);
   // ----------------------------------------------------------------
   // Settings registers
   // ----------------------------------------------------------------
   logic [3:0] slot_reg [pin_cfg_pkg::PIN_COUNT];
   logic [3:0] slot_next [pin_cfg_pkg::PIN_COUNT];
   logic port_sel_reg;
   logic port_sel_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [3:0] remote_sync;
   logic [3:0] pin_a_sync;
   logic [3:0] pin_b_sync;
   logic [3:0] drv_value;
   logic [3:0] drv_oe_n;
   logic [3:0] in_state;
   pin_cfg_pkg::pin_mode_type mode [pin_cfg_pkg::PIN_COUNT];

   // Writes land in the nibble slots; read-only nibbles are dropped.
   always_comb
   begin
      for (int i = 0; i < pin_cfg_pkg::PIN_COUNT; i++)
      begin
         slot_next[i] = slot_reg[i];
      end
      port_sel_next = port_sel_reg;
      if (WR_IN)
      begin
         unique case (ADDR_IN)
            pin_cfg_pkg::ADDR_PIN0:
            begin
               slot_next[0] = WDATA_IN[pin_cfg_pkg::SLOT_LO +: 4];
            end
            pin_cfg_pkg::ADDR_PIN12:
            begin
               slot_next[1] = WDATA_IN[pin_cfg_pkg::SLOT_LO +: 4];
               slot_next[2] = WDATA_IN[pin_cfg_pkg::SLOT_HI +: 4];
            end
            pin_cfg_pkg::ADDR_PIN3:
            begin
               slot_next[3] = WDATA_IN[pin_cfg_pkg::SLOT_LO +: 4];
            end
            pin_cfg_pkg::ADDR_CTRL:
            begin
               port_sel_next = WDATA_IN[0];
            end
            default:
            begin
               port_sel_next = port_sel_reg;
            end
         endcase
      end
   end

   // Read data stands one cycle after the read strobe only.
   always_comb
   begin
      rdata_next = pin_cfg_pkg::BYTE_ZERO;
      if (RD_IN)
      begin
         unique case (ADDR_IN)
            pin_cfg_pkg::ADDR_PIN0:
            begin
               rdata_next = {pin_cfg_pkg::REVISION_VALUE, slot_reg[0]};
            end
            pin_cfg_pkg::ADDR_PIN12:
            begin
               rdata_next = {slot_reg[2], slot_reg[1]};
            end
            pin_cfg_pkg::ADDR_PIN3:
            begin
               rdata_next = {pin_cfg_pkg::SLOT_RESET, slot_reg[3]};
            end
            pin_cfg_pkg::ADDR_CTRL:
            begin
               rdata_next = {7'h00, port_sel_reg};
            end
            pin_cfg_pkg::ADDR_STATUS:
            begin
               rdata_next = {4'h0, in_state};
            end
            default:
            begin
               rdata_next = pin_cfg_pkg::BYTE_ZERO;
            end
         endcase
      end
   end

   // Settings registers; the next values come from the write decode.
   always_ff @(posedge CLK_SYS_IN)
   begin
      if (SRST_IN)
      begin
         for (int i = 0; i < pin_cfg_pkg::PIN_COUNT; i++)
         begin
            slot_reg[i] <= pin_cfg_pkg::SLOT_RESET;
         end
         port_sel_reg <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < pin_cfg_pkg::PIN_COUNT; i++)
         begin
            slot_reg[i] <= slot_next[i];
         end
         port_sel_reg <= port_sel_next;
      end
   end

   // Read data register, kept apart so a read never touches the settings.
   always_ff @(posedge CLK_SYS_IN)
   begin
      if (SRST_IN)
      begin
         rdata_reg <= pin_cfg_pkg::BYTE_ZERO;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end
   assign RDATA_OUT = rdata_reg;

   // ----------------------------------------------------------------
   // Per-pin drivers
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < pin_cfg_pkg::PIN_COUNT; g++)
      begin : gen_pin
         pin_slot_if slot_bus ();
         assign slot_bus.slot = slot_reg[g];
         pin_sync remote_sync_i
         (
            .clk_in(CLK_SYS_IN),
            .srst_in(SRST_IN),
            .async_in(REMOTE_VALUE_IN[g]),
            .sync_out(remote_sync[g])
         );
         pin_sync pin_a_sync_i
         (
            .clk_in(CLK_SYS_IN),
            .srst_in(SRST_IN),
            .async_in(PIN_A_IN[g]),
            .sync_out(pin_a_sync[g])
         );
         pin_sync pin_b_sync_i
         (
            .clk_in(CLK_SYS_IN),
            .srst_in(SRST_IN),
            .async_in(PIN_B_IN[g]),
            .sync_out(pin_b_sync[g])
         );
         pin_driver driver_i
         (
            .cfg(slot_bus.sink),
            .remote_value_in(remote_sync[g]),
            .func_value_in(FUNC_VALUE_IN[g]),
            .drive_value_out(drv_value[g]),
            .drive_oe_n_out(drv_oe_n[g]),
            .mode_out(mode[g])
         );
      end
   endgenerate

   // Global codes are unused because every pin has its own code.
   logic unused_global;
   assign unused_global = ^GLOBAL_DIR_EN_IN;

   // Resolved modes are kept for inspection only; nothing steers on them.
   logic unused_mode;
   assign unused_mode = ^{mode[0], mode[1], mode[2], mode[3]};

   // Unselected port keeps its functional output role.
   always_comb
   begin
      if (port_sel_reg)
      begin
         PIN_B_OUT = drv_value;
         PIN_B_OE_N_OUT = drv_oe_n;
         PIN_A_OUT = FUNC_VALUE_IN;
         PIN_A_OE_N_OUT = 4'h0;
         in_state = pin_b_sync;
      end
      else
      begin
         PIN_A_OUT = drv_value;
         PIN_A_OE_N_OUT = drv_oe_n;
         PIN_B_OUT = FUNC_VALUE_IN;
         PIN_B_OE_N_OUT = 4'h0;
         in_state = pin_a_sync;
      end
   end
endmodule : pin_cfg_top
`default_nettype wire

// file: sim/pin_cfg_props.sv
// Purpose: Port checks for the pin configuration block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Mirrors the port select to find the steered pins.
`timescale 1ns/1ns
`default_nettype none
module pin_cfg_props
(
   input wire logic CLK_SYS_IN,
   input wire logic SRST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [7:0] RDATA_OUT,
   input wire logic [3:0] FUNC_VALUE_IN,
   input wire logic [3:0] PIN_A_OUT,
   input wire logic [3:0] PIN_A_OE_N_OUT,
   input wire logic [3:0] PIN_B_OUT,
   input wire logic [3:0] PIN_B_OE_N_OUT
);
   logic sel_reg;
   logic sel_next;
   logic w0;
   logic w3;
   logic [3:0] s_out;
   logic [3:0] s_oe;
   // The idle port is the one the select does not steer.
   assign sel_next = (WR_IN && ADDR_IN == 8'h30) ? WDATA_IN[0] : sel_reg;
   assign w0 = WR_IN && ADDR_IN == 8'h1D;
   assign w3 = WR_IN && ADDR_IN == 8'h1F;
   assign s_out = sel_reg ? PIN_B_OUT : PIN_A_OUT;
   assign s_oe = sel_reg ? PIN_B_OE_N_OUT : PIN_A_OE_N_OUT;
   // Mirror register for the port select.
   always_ff @(posedge CLK_SYS_IN)
      sel_reg <= SRST_IN ? 1'b0 : sel_next;
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (SRST_IN);
   rdata_idle_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
      else $error("read data not idle");
   rev_field_a: assert property (RD_IN && ADDR_IN == 8'h1D |=>
      RDATA_OUT[7:4] == pin_cfg_pkg::REVISION_VALUE)
      else $error("revision field wrong");
   rsvd_zero_a: assert property (RD_IN && ADDR_IN == 8'h1F |=> RDATA_OUT[7:4] == 4'h0)
      else $error("reserved bits not zero");
   func_role_a: assert property (w0 && WDATA_IN[2:0] == 3'b000 |=>
      !s_oe[0] && s_out[0] == FUNC_VALUE_IN[0])
      else $error("functional pin wrong");
   tri_code_a: assert property (w0 && WDATA_IN[2:0] == 3'b010 |=> s_oe[0])
      else $error("pin not released");
   gp_out_a: assert property (w3 && WDATA_IN[2:0] == 3'b001 |=>
      !s_oe[3] && s_out[3] == $past(WDATA_IN[3]))
      else $error("output value not driven");
   gp_in_a: assert property (WR_IN && ADDR_IN == 8'h1E && WDATA_IN[6:4] == 3'b011 |=>
      s_oe[2])
      else $error("pin 2 not input");
   link_force_a: assert property (w0 && WDATA_IN[2] |=> !s_oe[0])
      else $error("link pin not driven");
   idle_port_a: assert property ((sel_reg ? PIN_A_OE_N_OUT : PIN_B_OE_N_OUT) == 4'h0
      && (sel_reg ? PIN_A_OUT : PIN_B_OUT) == FUNC_VALUE_IN)
      else $error("idle port wrong");
endmodule : pin_cfg_props
`default_nettype wire

// file: sim/link_partner.sv
// Purpose: Remote serializer model sending pin values on the link.
// Assumes: Values change only when the bench commands them.
// Notes: Slow mode adds three cycles of link delay.
`timescale 1ns/1ns
`default_nettype none
module link_partner
(
   input wire logic clk_in,
   input wire logic slow_in,
   input wire logic [3:0] cmd_in,
   output logic [3:0] value_out
);
   logic [11:0] pipe_reg;
   // A slow link hands over the oldest stage of the delay line.
   always_ff @(posedge clk_in)
   begin
      pipe_reg <= {pipe_reg[7:0], cmd_in};
      value_out <= slow_in ? pipe_reg[11:8] : cmd_in;
   end
endmodule : link_partner
`default_nettype wire

// file: sim/pin_cfg_top_tb.sv
// Purpose: Self-checking bench for the pin configuration block.
// Assumes: Pin levels resolve from each side's output enable.
// Notes: Random settings each round; a queue holds expected results.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module pin_cfg_top_tb;
   typedef struct {logic pin; logic [15:0] v; logic [15:0] m;} note_type;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic rd_q = 1'b0;
   logic pin_q = 1'b0;
   logic slow = 1'b0;
   logic [7:0] rdata;
   logic [3:0] func_v = 4'hA;
   logic [3:0] glob = 4'h0;
   logic [3:0] ext_a = 4'h0;
   logic [3:0] ext_b = 4'h0;
   logic [3:0] cmd = 4'h0;
   logic [3:0] remote, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
   logic [31:0] seed = 32'h0000_2A4D;
   int err_count = 0;
   int checks_done = 0;
   note_type q[$];
   note_type n;
   // A released pin shows what the outside world drives.
   assign pa_in = (pa_oe & ext_a) | (~pa_oe & pa_out);
   assign pb_in = (pb_oe & ext_b) | (~pb_oe & pb_out);
   initial forever #25 clk = ~clk;
   pin_cfg_top dut (.CLK_SYS_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .REMOTE_VALUE_IN(remote),
      .FUNC_VALUE_IN(func_v), .GLOBAL_DIR_EN_IN(glob), .PIN_A_IN(pa_in), .PIN_A_OUT(pa_out),
      .PIN_A_OE_N_OUT(pa_oe), .PIN_B_IN(pb_in), .PIN_B_OUT(pb_out), .PIN_B_OE_N_OUT(pb_oe));
   link_partner u_link (.clk_in(clk), .slow_in(slow), .cmd_in(cmd), .value_out(remote));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // pin resolution, as {value, oe_n, value kept}.
   function automatic logic [2:0] pin_exp(logic [3:0] c, logic f, logic r);
      if (c[2]) return {r, 2'b01};
      case (c[1:0])
         2'b00: return {f, 2'b01};
         2'b01: return {c[3], 2'b01};
         default: return 3'b010;
      endcase
   endfunction : pin_exp
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      q.push_back('{1'b0, {8'h00, e}, 16'hFFFF});
      @(posedge clk);
      rd_s <= 1'b0;
   endtask : bus_rd
   task automatic pin_chk(input logic [15:0] e, input logic [15:0] m);
      @(posedge clk);
      q.push_back('{1'b1, e, m});
      pin_q <= 1'b1;
      @(posedge clk);
      pin_q <= 1'b0;
   endtask : pin_chk
   task automatic reset_chk();
      @(posedge clk);
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      pin_chk({func_v, 4'h0, func_v, 4'h0}, 16'hFFFF);
      bus_rd(8'h1D, {pin_cfg_pkg::REVISION_VALUE, 4'h0});
      bus_rd(8'h1E, 8'h00);
   endtask : reset_chk
   // Every pin code once, so each pin assertion has a case to judge.
   task automatic directed();
      bus_wr(8'h1D, 8'h02);
      bus_wr(8'h1D, 8'h00);
      bus_wr(8'h1D, 8'h04);
      bus_wr(8'h1F, 8'h09);
      bus_wr(8'h1E, 8'h30);
      repeat (4) @(posedge clk);
      pin_chk({4'hA, 4'h4, 4'hA, 4'h0}, {4'hB, 4'hF, 8'hFF});
   endtask : directed
   // One round: random settings, link values, port choice and pin levels.
   task automatic round();
      logic [31:0] v;
      logic [31:0] c;
      logic [2:0] p;
      logic [3:0] so, se, sm, lv;
      v = rnd();
      c = rnd();
      func_v <= v[3:0];
      glob <= v[7:4];
      ext_a <= v[11:8];
      ext_b <= v[15:12];
      cmd <= v[19:16];
      slow <= v[20];
      bus_wr(8'h30, {7'h00, v[21]});
      bus_wr(8'h1D, c[7:0]);
      bus_wr(8'h1E, c[15:8]);
      bus_wr(8'h1F, c[23:16]);
      bus_wr(8'h55, c[31:24]);
      repeat (8) @(posedge clk);
      for (int i = 0; i < 4; i++)
      begin
         p = pin_exp(i == 0 ? c[3:0] : c[4*i+4 +: 4], v[i], v[16+i]);
         {so[i], se[i], sm[i]} = p;
         lv[i] = se[i] ? (v[21] ? v[12+i] : v[8+i]) : so[i];
      end
      pin_chk(v[21] ? {v[3:0], 4'h0, so, se} : {so, se, v[3:0], 4'h0},
         v[21] ? {8'hFF, sm, 4'hF} : {sm, 4'hF, 8'hFF});
      bus_rd(8'h31, {4'h0, lv});
      bus_rd(8'h1D, {pin_cfg_pkg::REVISION_VALUE, c[3:0]});
      bus_rd(8'h1E, c[15:8]);
      bus_rd(8'h1F, {4'h0, c[19:16]});
      bus_rd(8'h55, 8'h00);
   endtask : round
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   // Read data and pin states are compared against the oldest note.
   always @(posedge clk) rd_q <= rd_s;
   always @(negedge clk)
   begin
      if ((rd_q || pin_q) && q.size() > 0)
      begin
         n = q.pop_front();
         `CHK((n.pin ? {pa_out, pa_oe, pb_out, pb_oe} : {8'h00, rdata}) & n.m, n.v & n.m)
      end
   end
   initial
   begin
      reset_chk();
      $display("reset test done");
      directed();
      $display("directed test done");
      for (int r = 0; r < 24; r++)
      begin
         round();
      end
      $display("random rounds done");
      reset_chk();
      $display("second reset test done");
      close_out();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      err_count++;
      $display("[ERR] %0t timeout", $time);
      close_out();
   end
endmodule : pin_cfg_top_tb
bind pin_cfg_top pin_cfg_props u_props (.CLK_SYS_IN, .SRST_IN, .ADDR_IN, .WDATA_IN, .WR_IN,
   .RD_IN, .RDATA_OUT, .FUNC_VALUE_IN, .PIN_A_OUT, .PIN_A_OE_N_OUT, .PIN_B_OUT, .PIN_B_OE_N_OUT);
`default_nettype wire
